// >>> cipher_host_port.sv
// Purpose: Host data, DMA, interrupt and initial vector port of a cipher.
// Assumes: AHB-Lite slave, zero wait states, core on the same clock.
// Notes: Cipher core, keys and lengths live outside this block.
// Functional notes
// - Blocks are four 32-bit words, 16 bytes.
// - Output ready flag gates result block reads.
// - Input ready flag shows input registers free.
// - Four DMA requests, each enabled separately.
// - Eight interrupt sources, including four DMA-done.
// - Only DMA-done flags are software clearable.
// - Enable and disable touch only selected bits.
// - Raw and masked status readable, same layout.
// - Initial vector is four words, low first.
// - Save context keeps updated vector readable.
// - Combined modes pass AAD, end with tag.
//
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "cipher_port_defs.svh"
module cipher_host_port
   import cipher_port_pkg::*;
(
   input wire logic clk, // 10 MHz clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic hsel, // Slave select.
   input wire logic [7:0] haddr, // Byte address.
   input wire logic [1:0] htrans, // Transfer type.
   input wire logic hwrite, // Write when high.
   input wire logic [2:0] hsize, // Transfer size, word only.
   input wire logic [31:0] hwdata, // Write data.
   input wire logic hready, // Bus ready.
   output logic [31:0] hrdata, // Read data.
   output logic hreadyout, // Slave ready.
   output logic hresp, // Always OKAY.
   output logic irq, // Level interrupt.
   output logic [3:0] dma_req, // Requests: din, dout, cin, cout.
   input wire logic [3:0] dma_done, // DMA done pulses, same order.
   output core_req_type core_req, // Block towards the core.
   output logic core_req_valid, // Input block held for the core.
   input wire logic core_req_take, // Core took the block, pulse.
   input wire logic [127:0] core_result, // Result block.
   input wire logic core_result_valid, // Result strobe, pulse.
   input wire logic ctx_in_ready, // Core can take context, level.
   input wire logic [127:0] core_iv_next, // Updated vector.
   input wire logic core_iv_valid, // Updated vector strobe, pulse.
   input wire logic core_tag_valid // Tag ready at end of operation.
);
   // Address phase captured for the following data phase.
   logic wr_pend; // Write data phase pending.
   logic [7:0] wr_addr; // Address of the pending write.
   // Control and status state.
   logic [1:0] ctrl; // Save context and AAD bits.
   logic [3:0] dma_en; // DMA request enables.
   logic [7:0] irq_mask; // Interrupt enables.
   logic [3:0] dma_flag; // Sticky DMA-done flags.
   logic ctx_out_flag; // Context output available.
   in_state_type in_state; // Input holder state.
   logic [3:0] in_seen; // Input words written so far.
   logic [127:0] in_buf; // Input block words.
   logic [127:0] out_buf; // Result block words.
   logic out_rdy; // Result block available.
   logic [3:0] out_seen; // Result words read so far.
   logic [127:0] iv; // Initial vector words.

   // Word index of a data or vector address; address bits 3:2 select word.
   function automatic logic [1:0] word_of(input logic [7:0] a);
      word_of = a[3:2];
   endfunction

   // Decode of the address phase.
   wire logic take = hsel & htrans[1] & hready;
   wire logic rd_take = take & ~hwrite;
   wire logic [7:0] rd_base = {haddr[7:4], 4'h0};
   wire logic [1:0] rd_word = word_of(haddr);
   // Decode of the write data phase.
   wire logic [7:0] wr_base = {wr_addr[7:4], 4'h0};
   wire logic [1:0] wr_word = word_of(wr_addr);
   wire logic wr_ctrl = wr_pend & (wr_addr == `OFS_CTRL);
   wire logic wr_dma = wr_pend & (wr_addr == `OFS_DMA_EN);
   wire logic wr_raw = wr_pend & (wr_addr == `OFS_IRQ_RAW);
   wire logic wr_mask = wr_pend & (wr_addr == `OFS_IRQ_MASK);
   wire logic wr_set = wr_pend & (wr_addr == `OFS_IRQ_SET);
   wire logic wr_clr = wr_pend & (wr_addr == `OFS_IRQ_CLR);
   wire logic wr_data = wr_pend & (wr_base == `OFS_DATA0);
   wire logic wr_iv = wr_pend & (wr_base == `OFS_IV0);

   // Status: input and output ready levels and the eight sources.
   wire logic in_rdy = (in_state == IN_OPEN);
   wire logic [7:0] raw = {dma_flag, out_rdy, in_rdy, ctx_out_flag,
      ctx_in_ready};
   wire logic [7:0] mis = raw & irq_mask;
   wire logic [31:0] ctrl_rd = {28'h0000000, out_rdy, in_rdy, ctrl};
   // Input words complete the block once every word has been written.
   wire logic [3:0] in_seen_n = in_seen | (4'h1 << wr_word);
   wire logic in_last = wr_data & in_rdy & (in_seen_n == 4'hF);
   // Result block is released once every word has been read.
   wire logic rd_out = rd_take & (rd_base == `OFS_DATA0) & out_rdy;
   wire logic [3:0] out_seen_n = out_seen | (4'h1 << rd_word);
   wire logic out_last = rd_out & (out_seen_n == 4'hF);

   // Read mux for the address phase; unmapped words read as zero.
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = 32'h00000000;
      if (rd_base == `OFS_DATA0) begin
         // Result words are only shown while a block is ready.
         if (out_rdy) begin
            next_rdata = out_buf[rd_word*32 +: 32];
         end
      end else if (rd_base == `OFS_IV0) begin
         next_rdata = iv[rd_word*32 +: 32];
      end else begin
         unique case (haddr)
            `OFS_CTRL: next_rdata = ctrl_rd;
            `OFS_DMA_EN: next_rdata = {28'h0000000, dma_en};
            `OFS_IRQ_RAW: next_rdata = {24'h000000, raw};
            `OFS_IRQ_MASK: next_rdata = {24'h000000, irq_mask};
            `OFS_IRQ_MIS: next_rdata = {24'h000000, mis};
            default: next_rdata = 32'h00000000;
         endcase
      end
   end

   // Bus side: capture address phase, answer with zero wait states.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend <= take & hwrite;
         wr_addr <= haddr;
         hrdata <= next_rdata;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Control, DMA enable and interrupt mask registers.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= `RST_CTRL;
         dma_en <= `RST_DMA_EN;
         irq_mask <= `RST_MASK;
      end else begin
         if (wr_ctrl) begin
            ctrl <= hwdata[1:0];
         end
         if (wr_dma) begin
            dma_en <= hwdata[3:0];
         end
         // Set and clear strobes leave unselected enables alone.
         if (wr_mask) begin
            irq_mask <= hwdata[7:0];
         end else if (wr_set) begin
            irq_mask <= irq_mask | hwdata[7:0];
         end else if (wr_clr) begin
            irq_mask <= irq_mask & ~hwdata[7:0];
         end
      end
   end

   // Sticky DMA-done flags; a new done beats a same-cycle clear.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dma_flag <= 4'h0;
      end else begin
         dma_flag <= (dma_flag &
            ~(wr_raw ? hwdata[7:4] : 4'h0)) | dma_done;
      end
   end

   // Input block holder: collects four words, then offers them.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_state <= IN_OPEN;
         in_seen <= 4'h0;
         in_buf <= 128'h0;
      end else begin
         unique case (in_state)
            IN_OPEN: begin
               // Writes while held are dropped; host must poll first.
               if (wr_data) begin
                  in_buf[wr_word*32 +: 32] <= hwdata;
                  in_seen <= in_last ? 4'h0 : in_seen_n;
               end
               if (in_last) begin
                  in_state <= IN_HELD;
               end
            end
            IN_HELD: begin
               if (core_req_take) begin
                  in_state <= IN_OPEN;
               end
            end
         endcase
      end
   end

   // Result block: captured from the core, released by the reads.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_rdy <= 1'b0;
         out_seen <= 4'h0;
         out_buf <= 128'h0;
      end else begin
         if (core_result_valid & ~out_rdy) begin
            out_buf <= core_result;
            out_rdy <= 1'b1;
         end else if (out_last) begin
            out_rdy <= 1'b0;
         end
         if (rd_out) begin
            out_seen <= out_last ? 4'h0 : out_seen_n;
         end
      end
   end

   // Initial vector: host writes words, core updates when saving.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         iv <= 128'h0;
         ctx_out_flag <= 1'b0;
      end else begin
         if (wr_iv) begin
            iv[wr_word*32 +: 32] <= hwdata;
         end else if (core_iv_valid & ctrl[`BIT_SAVE_CTX]) begin
            iv <= core_iv_next;
         end
         // With save context set, context out is up from tag or vector until the next vector write.
         if ((core_tag_valid | core_iv_valid) & ctrl[`BIT_SAVE_CTX]) begin
            ctx_out_flag <= 1'b1;
         end else if (wr_iv) begin
            ctx_out_flag <= 1'b0;
         end
      end
   end

   // Registered outputs towards core, DMA and interrupt controller.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_req <= '0;
         core_req_valid <= 1'b0;
         dma_req <= 4'h0;
         irq <= 1'b0;
      end else begin
         core_req <= {in_buf, iv, ctrl[`BIT_AAD]};
         core_req_valid <= (in_state == IN_HELD) & ~core_req_take;
         dma_req <= dma_en & {ctx_out_flag, ctx_in_ready, out_rdy,
            in_rdy};
         irq <= |mis;
      end
   end

   // Checks kept beside the logic.
   // The interrupt pin lags the masked status by its output register.
   chk_irq_follows_mask: assert property (
      @(posedge clk) disable iff (!rst_n)
      irq == $past(|mis))
      else $error("irq does not follow masked status");
   // The masked status read back over the bus carries only enabled bits.
   chk_mis_layout: assert property (
      @(posedge clk) disable iff (!rst_n)
      rd_take & (haddr == `OFS_IRQ_MIS) |=>
         hrdata == {24'h000000, $past(raw) & $past(irq_mask)})
      else $error("masked status wrong");
   // A done pulse must leave its flag set on the next cycle.
   chk_done_sticks: assert property (
      @(posedge clk) disable iff (!rst_n)
      dma_done[0] |=> dma_flag[0])
      else $error("dma done lost");
   // Without a clear write a done flag never drops.
   chk_flag_holds: assert property (
      @(posedge clk) disable iff (!rst_n)
      dma_flag[3] & ~wr_raw |=> dma_flag[3])
      else $error("flag dropped");
   // A clear write with no new pulse must drop the selected flag.
   chk_dma_clear: assert property (
      @(posedge clk) disable iff (!rst_n)
      wr_raw & hwdata[4] & ~dma_done[0] |=> ~dma_flag[0])
      else $error("done flag not cleared");
   // Enabling sources may only add bits to the mask.
   chk_set_keeps: assert property (
      @(posedge clk) disable iff (!rst_n)
      wr_set |=> (irq_mask & $past(irq_mask)) == $past(irq_mask))
      else $error("enable cleared a bit");
   // Disabling sources may only remove bits from the mask.
   chk_clr_keeps: assert property (
      @(posedge clk) disable iff (!rst_n)
      wr_clr |=> (irq_mask | $past(irq_mask)) == $past(irq_mask))
      else $error("disable set a bit");
   // A disabled request source stays quiet.
   chk_dma_gate: assert property (
      @(posedge clk) disable iff (!rst_n)
      ~dma_en[1] |=> ~dma_req[1])
      else $error("disabled dma request");
   // A completed input block closes the holder, then is offered.
   chk_block_held: assert property (
      @(posedge clk) disable iff (!rst_n)
      in_last |=> ~in_rdy ##1 core_req_valid)
      else $error("block not offered");
   // Reading the last result word frees the output holder.
   chk_out_release: assert property (
      @(posedge clk) disable iff (!rst_n)
      out_last |=> ~out_rdy)
      else $error("output not released");
   // A data read with no result ready must return zero.
   chk_out_gated: assert property (
      @(posedge clk) disable iff (!rst_n)
      rd_take & (rd_base == `OFS_DATA0) & ~out_rdy |=>
         hrdata == 32'h00000000)
      else $error("result shown while not ready");
   // With save context set, the core's vector replaces the stored one.
   chk_iv_save: assert property (
      @(posedge clk) disable iff (!rst_n)
      core_iv_valid & ~wr_iv & ctrl[0] |=> iv == $past(core_iv_next))
      else $error("vector not saved");
   // A counted result read returns the addressed word.
   chk_result_data: assert property (
      @(posedge clk) disable iff (!rst_n)
      rd_out |=> hrdata == $past(out_buf[rd_word*32 +: 32]))
      else $error("result word wrong");
endmodule

// >>> cipher_port_defs.svh
// Purpose: Offsets, field positions and reset values of the cipher port.
// Assumes: Word-aligned 32-bit AHB-Lite registers.
// Notes: Included by the port module and by its bench.
`ifndef CIPHER_PORT_DEFS_SVH
`define CIPHER_PORT_DEFS_SVH
`define OFS_CTRL 8'h00
`define OFS_DMA_EN 8'h04
`define OFS_IRQ_RAW 8'h08
`define OFS_IRQ_MASK 8'h0C
`define OFS_IRQ_MIS 8'h10
`define OFS_IRQ_SET 8'h14
`define OFS_IRQ_CLR 8'h18
`define OFS_DATA0 8'h20
`define OFS_IV0 8'h30
`define BIT_SAVE_CTX 0
`define BIT_AAD 1
`define BIT_IN_RDY 2
`define BIT_OUT_RDY 3
`define DMA_DONE_LSB 4
`define RST_CTRL 2'h0
`define RST_DMA_EN 4'h0
`define RST_MASK 8'h00
`define BLOCK_WORDS 4
`endif

// >>> cipher_port_pkg.sv
// Purpose: Types shared by the cipher port and its users.
// Assumes: Constants come from the defs header.
// Notes: Carriers are packed structs.
package cipher_port_pkg;
   // Block handed to the cipher core.
   typedef struct packed {
      logic [127:0] block;
      logic [127:0] initial_vector;
      logic aad;
   } core_req_type;
   // Input block holder state.
   typedef enum logic [1:0] {
      IN_OPEN = 2'b01,
      IN_HELD = 2'b10
   } in_state_type;
endpackage

// >>> core_model.sv
// Purpose: Behavioural cipher core facing the host port.
// Assumes: Same clock as the port; strobes are one-cycle pulses.
// Notes: Result is block xor vector, a stand-in for the real cipher.
`timescale 1ns/100ps
module core_model
   import cipher_port_pkg::*;
(
   input wire logic clk, // Port clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire core_req_type core_req, // Block from the port.
   input wire logic core_req_valid, // Block held for us.
   output logic core_req_take, // Block consumed, pulse.
   output logic [127:0] core_result, // Result block.
   output logic core_result_valid, // Result strobe.
   output logic ctx_in_ready, // Idle, can take context.
   output logic [127:0] core_iv_next, // Updated vector.
   output logic core_iv_valid, // Vector strobe.
   output logic core_tag_valid // Tag done strobe.
);
   logic busy; // Working on a block.
   logic [3:0] cnt; // Processing delay counter.
   logic [127:0] res; // Pending result.
   logic [127:0] nxt; // Pending vector.
   assign ctx_in_ready = !busy;
   // Data lines toggle outside strobes so stale values are never trusted.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
         cnt <= 4'h0;
         core_req_take <= 1'b0;
         core_result_valid <= 1'b0;
         core_iv_valid <= 1'b0;
         core_tag_valid <= 1'b0;
         core_result <= '0;
         core_iv_next <= '0;
      end else begin
         core_req_take <= 1'b0;
         core_result_valid <= 1'b0;
         core_iv_valid <= 1'b0;
         core_tag_valid <= 1'b0;
         core_result <= ~core_result;
         core_iv_next <= ~core_iv_next;
         if (!busy && core_req_valid) begin
            busy <= 1'b1;
            cnt <= 4'h0;
            core_req_take <= 1'b1;
            res <= core_req.block ^ core_req.initial_vector;
            nxt <= core_req.block;
         end else if (busy) begin
            cnt <= cnt + 4'h1;
            if (cnt == 4'h4) begin
               busy <= 1'b0;
               core_result_valid <= 1'b1;
               core_iv_valid <= 1'b1;
               core_tag_valid <= 1'b1;
               core_result <= res;
               core_iv_next <= nxt;
            end
         end
      end
   end
endmodule

// >>> block_cipher_host_port_test.sv
// Purpose: Self-checking bench for the cipher host port.
// Assumes: Single AHB-Lite master, zero wait states allowed for.
// Notes: Waits are bounded; a hang ends in the closing report.
`timescale 1ns/100ps
`include "cipher_port_defs.svh"
module block_cipher_host_port_test
   import cipher_port_pkg::*;
;
   logic clk, rst_n, hsel, hwrite, hreadyout, hresp, irq; // Bus and irq.
   logic [7:0] haddr; // Byte address.
   logic [1:0] htrans; // Transfer type.
   logic [2:0] hsize; // Always a word.
   logic [31:0] hwdata, hrdata, q; // Data and last read.
   logic [3:0] dma_req, dma_done; // DMA lines.
   core_req_type core_req; // Block towards the core.
   logic crv, take, rv, cir, ivv, tagv; // Core handshakes.
   logic [127:0] res, ivn; // Core result and vector.
   logic [31:0] dw[4] = '{32'h1111_2222, 32'h3333_4444, 32'hA5A5_0F0F,
      32'hDEAD_BEEF}; // Input block, word 0 first.
   logic [31:0] iv[4] = '{32'h0302_0100, 32'h0706_0504, 32'h0B0A_0908,
      32'h0F0E_0D0C}; // Initial vector, word 0 first.
   int error_cnt = 0, n_checks = 0;
   cipher_host_port u_dut(.clk(clk), .rst_n(rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .dma_req(dma_req),
      .dma_done(dma_done), .core_req(core_req), .core_req_valid(crv),
      .core_req_take(take), .core_result(res), .core_result_valid(rv),
      .ctx_in_ready(cir), .core_iv_next(ivn), .core_iv_valid(ivv),
      .core_tag_valid(tagv));
   core_model u_core(.clk(clk), .rst_n(rst_n), .core_req(core_req),
      .core_req_valid(crv), .core_req_take(take), .core_result(res),
      .core_result_valid(rv), .ctx_in_ready(cir), .core_iv_next(ivn),
      .core_iv_valid(ivv), .core_tag_valid(tagv));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Prints the counts and the verdict, then ends the run.
   task summarize();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task check(input string nm, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // Waits for hready at a rising edge, giving up after a bound.
   task wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         error_cnt++;
         summarize();
      end
   endtask
   // One single word transfer; read data is taken at the closing edge.
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask
   // Polls one control bit until set; the host may not go on without it.
   task poll(input int b);
      int n;
      n = 0;
      do begin
         rd(`OFS_CTRL);
         n++;
      end while (q[b] !== 1'b1 && n < 50);
      check("ready poll", {31'h0, q[b]}, 32'h1);
      if (n >= 50)
         summarize();
   endtask
   initial begin
      rst_n = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'b00;
      hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0; dma_done = 4'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(`OFS_CTRL); check("ctrl", q, 32'h0000_0004);
      check("hresp", {31'h0, hresp}, 32'h0);
      rd(`OFS_IRQ_RAW); check("raw", q, 32'h0000_0005);
      wr(`OFS_IRQ_SET, 32'h1);
      wr(`OFS_IRQ_SET, 32'h4);
      rd(`OFS_IRQ_MASK); check("mask", q, 32'h5);
      rd(`OFS_IRQ_MIS); check("mis", q, 32'h5);
      repeat (2) @(posedge clk);
      check("irq", {31'h0, irq}, 32'h1);
      wr(`OFS_IRQ_CLR, 32'h1);
      rd(`OFS_IRQ_MASK); check("mask", q, 32'h4);
      wr(`OFS_IRQ_CLR, 32'h4);
      repeat (2) @(posedge clk);
      check("irq", {31'h0, irq}, 32'h0);
      wr(`OFS_IRQ_MASK, 32'h81);
      rd(`OFS_IRQ_MASK);
      check("mask direct", q, 32'h81);
      wr(`OFS_IRQ_MASK, 32'h0);
      wr(`OFS_DMA_EN, 32'hF);
      repeat (2) @(posedge clk);
      check("dma_req", {28'h0, dma_req}, 32'h5);
      wr(`OFS_DMA_EN, 32'h4);
      repeat (2) @(posedge clk);
      check("dma_req", {28'h0, dma_req}, 32'h4);
      wr(`OFS_DMA_EN, 32'h0);
      wr(`OFS_CTRL, 32'h1);
      for (int n = 0; n < 4; n++) wr(`OFS_IV0 + 8'(4 * n), iv[n]);
      for (int n = 0; n < 4; n++) begin
         rd(`OFS_IV0 + 8'(4 * n)); check("iv", q, iv[n]);
      end
      poll(`BIT_IN_RDY);
      for (int n = 0; n < 4; n++) wr(`OFS_DATA0 + 8'(4 * n), dw[n]);
      rd(`OFS_DATA0); check("early out", q, 32'h0);
      poll(`BIT_OUT_RDY);
      for (int n = 0; n < 4; n++) begin
         rd(`OFS_DATA0 + 8'(4 * n)); check("out", q, dw[n] ^ iv[n]);
      end
      rd(`OFS_CTRL); check("out rdy", q & 32'h8, 32'h0);
      rd(`OFS_IRQ_RAW); check("ctx out", q & 32'h2, 32'h2);
      for (int n = 0; n < 4; n++) begin
         rd(`OFS_IV0 + 8'(4 * n)); check("iv saved", q, dw[n]);
      end
      dma_done <= 4'hF;
      @(posedge clk);
      dma_done <= 4'h0;
      rd(`OFS_IRQ_RAW); check("done", q & 32'hF0, 32'hF0);
      wr(`OFS_IRQ_SET, 32'hF0);
      repeat (2) @(posedge clk);
      check("irq", {31'h0, irq}, 32'h1);
      wr(`OFS_IRQ_RAW, 32'h3F);
      rd(`OFS_IRQ_RAW); check("w1c", q & 32'hFF, 32'hC7);
      wr(`OFS_IRQ_RAW, 32'hC0);
      repeat (2) @(posedge clk);
      check("irq", {31'h0, irq}, 32'h0);
      // Context out is up after the saved vector, so all but the dout request show.
      wr(`OFS_DMA_EN, 32'hF);
      repeat (2) @(posedge clk);
      check("dma_req", {28'h0, dma_req}, 32'hD);
      wr(`OFS_CTRL, 32'h3);
      rd(`OFS_CTRL);
      check("ctrl aad", q & 32'h3, 32'h3);
      check("aad", {31'h0, core_req.aad}, 32'h1);
      summarize();
   end
endmodule
